/* File: core/dw_pkg.sv */
/*
 Constants, command codes and state encodings shared by both ends of the
 two-wire dual wiper link. Assumes both ends are compiled after this package.
*/
// What this block does
// - Slave never drives clock; master makes clock, START, STOP
// - SDA falling while SCL high is START
// - SDA rising while SCL high is STOP
// - SDA changes only while SCL low
// - SDA change with SCL high is control, not data
// - Master starts only on an idle bus; the master end goes to START on i_go without sensing the bus
// - Bytes MSB first, ninth bit acknowledged by receiver
// - Control byte: code, three select bits, direction
// - Matching control byte is acknowledged
// - Acknowledge holds SDA low through clock high
// - Receiver slave acknowledges every received byte
// - Master chooses number of data bytes
// - Transfer ends with STOP or repeated START
// - Read returns wiper 0 first
// - Master acknowledge brings wiper 1 next
// - Master acknowledges all read bytes but last
// - Unacknowledged byte: slave releases SDA high
// - Two 8-bit wipers, ff high end, 00 low
// - Wipers clear to 00 at power-up
// - Write: control byte, then command byte
// - Commands write wiper 0, wiper 1, or both
// - Write wiper 0 may take wiper 1 next
package dw_pkg;

   // Arbitrary device code, replaces the fixed control code
   localparam logic [3:0] DEV_CODE_DEFAULT = 4'ha;
   localparam int         RNW_BIT          = 0;
   localparam int         SEL_LSB          = 1;
   localparam int         CODE_LSB         = 4;

   localparam logic [7:0] CMD_WR0          = 8'ha9;
   localparam logic [7:0] CMD_WR1          = 8'haa;
   localparam logic [7:0] CMD_WRB          = 8'haf;

   localparam logic [7:0] WIPER_RST        = 8'h00;
   localparam logic [7:0] WIPER_HIGH_END   = 8'hff;

   localparam logic [3:0] LAST_BIT_CNT     = 4'h7;
   localparam logic [3:0] ACK_CNT          = 4'h8;

   localparam int         SYS_PERIOD_NS    = 4;
   localparam int         SCL_PERIOD_NS    = 64;
   localparam int         SCL_QTR          = SCL_PERIOD_NS / (4 * SYS_PERIOD_NS);

   typedef enum logic [4:0] {
      DS_IDLE = 5'b00001,
      DS_ADDR = 5'b00010,
      DS_CMD  = 5'b00100,
      DS_DATA = 5'b01000,
      DS_READ = 5'b10000
   } dw_dev_st_e;

   typedef enum logic [3:0] {
      TGT_W0   = 4'b0001,
      TGT_W1   = 4'b0010,
      TGT_BOTH = 4'b0100,
      TGT_NONE = 4'b1000
   } dw_tgt_e;

   typedef enum logic [3:0] {
      MS_IDLE  = 4'b0001,
      MS_START = 4'b0010,
      MS_BIT   = 4'b0100,
      MS_STOP  = 4'b1000
   } dw_mst_st_e;

endpackage

/* File: core/dw_link_if.sv */
/*
 Two-wire link between master end and wiper slave end. SDA is open drain with
 a pull-up, resolved here from both enables. SCL is driven by the master only.
*/
`timescale 1ns/1ps
interface dw_link_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic sda;

   assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

   modport mst (output scl, output m_sda_o, output m_sda_oe, input sda);
   modport dev (input scl, output s_sda_o, output s_sda_oe, input sda);
endinterface

/* File: core/dw_dev_end.sv */
/*
 Wiper slave end: two-wire slave holding two 8-bit wiper positions.
 Clocked by the link clock SCL alone; the START and STOP detectors are clocked
 by SDA edges. Assumes an active-low power-up reset and a master on the link.
*/
`timescale 1ns/1ps
module dw_dev_end #(
   parameter logic [3:0] DEV_CODE = dw_pkg::DEV_CODE_DEFAULT
) (
   input  wire logic       i_rst_n,
   dw_link_if.dev          link,
   input  wire logic       i_device_select_pin_bit0,
   input  wire logic       i_device_select_pin_bit1,
   input  wire logic       i_device_select_pin_bit2,
   output logic      [7:0] o_wiper_position_0,
   output logic      [7:0] o_wiper_position_1
);

   logic                start_tgl;
   logic                next_start_tgl;
   logic                stop_tgl;
   logic                next_stop_tgl;

   logic                bit_q;
   logic [2:0]          sel_meta;
   logic [2:0]          sel_sync;

   dw_pkg::dw_dev_st_e  state;
   dw_pkg::dw_dev_st_e  next_state;
   dw_pkg::dw_tgt_e     tgt;
   dw_pkg::dw_tgt_e     next_tgt;
   logic [3:0]          cnt;
   logic [3:0]          next_cnt;
   logic [7:0]          shreg;
   logic [7:0]          next_shreg;
   logic                rd_idx;
   logic                next_rd_idx;
   logic                sda_oe;
   logic                next_sda_oe;
   logic                start_seen;
   logic                stop_seen;
   logic [7:0]          wiper0;
   logic [7:0]          next_wiper0;
   logic [7:0]          wiper1;
   logic [7:0]          next_wiper1;
   logic [7:0]          full;
   logic                addr_ok;

   // Open drain: only ever pulls low, never touches SCL
   assign link.s_sda_o    = 1'b0;
   assign link.s_sda_oe   = sda_oe;
   assign o_wiper_position_0 = wiper0;
   assign o_wiper_position_1 = wiper1;

   // Bus conditions: SDA edge while SCL high
   always_comb begin
      next_start_tgl = link.scl ? ~start_tgl : start_tgl;
      next_stop_tgl  = link.scl ? ~stop_tgl : stop_tgl;
   end

   always_ff @(negedge link.sda or negedge i_rst_n) begin
      if (!i_rst_n) begin
         start_tgl <= 1'b0;
      end else begin
         start_tgl <= next_start_tgl;
      end
   end

   always_ff @(posedge link.sda or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stop_tgl <= 1'b0;
      end else begin
         stop_tgl <= next_stop_tgl;
      end
   end

   // Data is stable while SCL is high, so sample on the rising edge
   always_ff @(posedge link.scl or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bit_q    <= 1'b1;
         sel_meta <= 3'h0;
         sel_sync <= 3'h0;
      end else begin
         bit_q    <= link.sda;
         sel_meta <= {i_device_select_pin_bit2, i_device_select_pin_bit1, i_device_select_pin_bit0};
         sel_sync <= sel_meta;
      end
   end

   always_comb begin
      full    = {shreg[6:0], bit_q};
      addr_ok = (full[7:dw_pkg::CODE_LSB] == DEV_CODE) &&
                (full[dw_pkg::CODE_LSB-1:dw_pkg::SEL_LSB] == sel_sync);
   end

   // Byte engine: advances on falling SCL, where SDA may change
   always_comb begin
      next_state  = state;
      next_tgt    = tgt;
      next_cnt    = cnt;
      next_shreg  = shreg;
      next_rd_idx = rd_idx;
      next_sda_oe = 1'b0;
      next_wiper0 = wiper0;
      next_wiper1 = wiper1;
      if (start_tgl != start_seen) begin
         // START or repeated START restarts the frame; a partial byte is dropped
         next_state = dw_pkg::DS_ADDR;
         next_cnt   = 4'h0;
      end else if (stop_tgl != stop_seen) begin
         next_state = dw_pkg::DS_IDLE;
      end else begin
         unique case (state)
            dw_pkg::DS_IDLE: begin
               next_cnt = 4'h0;
            end
            dw_pkg::DS_ADDR, dw_pkg::DS_CMD, dw_pkg::DS_DATA: begin
               if (cnt != dw_pkg::ACK_CNT) begin
                  next_shreg = full;
                  next_cnt   = cnt + 4'h1;
                  if (cnt == dw_pkg::LAST_BIT_CNT) begin
                     if ((state == dw_pkg::DS_ADDR) && !addr_ok) begin
                        next_state = dw_pkg::DS_IDLE;
                     end else begin
                        next_sda_oe = 1'b1;
                     end
                  end
               end else begin
                  next_cnt = 4'h0;
                  if (state == dw_pkg::DS_ADDR) begin
                     if (shreg[dw_pkg::RNW_BIT]) begin
                        next_state  = dw_pkg::DS_READ;
                        next_shreg  = wiper0;
                        next_sda_oe = ~wiper0[7];
                        next_rd_idx = 1'b0;
                     end else begin
                        next_state = dw_pkg::DS_CMD;
                     end
                  end else if (state == dw_pkg::DS_CMD) begin
                     next_state = dw_pkg::DS_DATA;
                     case (shreg)
                        dw_pkg::CMD_WR0: next_tgt = dw_pkg::TGT_W0;
                        dw_pkg::CMD_WR1: next_tgt = dw_pkg::TGT_W1;
                        dw_pkg::CMD_WRB: next_tgt = dw_pkg::TGT_BOTH;
                        default:         next_tgt = dw_pkg::TGT_NONE;
                     endcase
                  end else begin
                     // Committed only after the acknowledge clock of a full byte
                     unique case (tgt)
                        dw_pkg::TGT_W0: begin
                           next_wiper0 = shreg;
                           next_tgt    = dw_pkg::TGT_W1;
                        end
                        dw_pkg::TGT_W1: begin
                           next_wiper1 = shreg;
                           next_tgt    = dw_pkg::TGT_NONE;
                        end
                        dw_pkg::TGT_BOTH: begin
                           next_wiper0 = shreg;
                           next_wiper1 = shreg;
                           next_tgt    = dw_pkg::TGT_NONE;
                        end
                        dw_pkg::TGT_NONE: begin
                           next_tgt = dw_pkg::TGT_NONE;
                        end
                     endcase
                  end
               end
            end
            dw_pkg::DS_READ: begin
               if (cnt < dw_pkg::LAST_BIT_CNT) begin
                  next_shreg  = {shreg[6:0], 1'b0};
                  next_sda_oe = ~shreg[6];
                  next_cnt    = cnt + 4'h1;
               end else if (cnt == dw_pkg::LAST_BIT_CNT) begin
                  next_cnt = dw_pkg::ACK_CNT;
               end else if (!bit_q && !rd_idx) begin
                  next_shreg  = wiper1;
                  next_sda_oe = ~wiper1[7];
                  next_cnt    = 4'h0;
                  next_rd_idx = 1'b1;
               end else begin
                  next_state = dw_pkg::DS_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(negedge link.scl or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state      <= dw_pkg::DS_IDLE;
         tgt        <= dw_pkg::TGT_NONE;
         cnt        <= 4'h0;
         shreg      <= 8'h00;
         rd_idx     <= 1'b0;
         sda_oe     <= 1'b0;
         start_seen <= 1'b0;
         stop_seen  <= 1'b0;
         wiper0     <= dw_pkg::WIPER_RST;
         wiper1     <= dw_pkg::WIPER_RST;
      end else begin
         state      <= next_state;
         tgt        <= next_tgt;
         cnt        <= next_cnt;
         shreg      <= next_shreg;
         rd_idx     <= next_rd_idx;
         sda_oe     <= next_sda_oe;
         // The toggles settle a half SCL period before this edge by protocol
         start_seen <= start_tgl;
         stop_seen  <= stop_tgl;
         wiper0     <= next_wiper0;
         wiper1     <= next_wiper1;
      end
   end

endmodule

/* File: core/dw_mst_end.sv */
/*
 Master end: makes SCL by dividing i_sys_clk, issues START, bytes and STOP.
 Assumes request inputs stay stable from i_go until o_done.
*/
`timescale 1ns/1ps
module dw_mst_end #(
   parameter logic [3:0]  DEV_CODE = dw_pkg::DEV_CODE_DEFAULT,
   parameter int unsigned QTR      = dw_pkg::SCL_QTR
) (
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   dw_link_if.mst          link,
   input  wire logic       i_go,
   input  wire logic       i_rnw,
   input  wire logic [2:0] i_sel,
   input  wire logic [7:0] i_cmd,
   input  wire logic [7:0] i_wdata0,
   input  wire logic [7:0] i_wdata1,
   input  wire logic [1:0] i_len,
   output logic            o_busy,
   output logic            o_done,
   output logic            o_nack,
   output logic      [7:0] o_rdata0,
   output logic      [7:0] o_rdata1
);

   localparam logic [7:0] QTR_LAST = 8'(QTR - 1);

   dw_pkg::dw_mst_st_e state, next_state;
   logic [7:0] qcnt, next_qcnt;
   logic [1:0] q, next_q;
   logic [3:0] bi, next_bi;
   logic [2:0] k, next_k;
   logic [7:0] sh, next_sh;
   logic       scl, next_scl;
   logic       oe, next_oe;
   logic       done, next_done;
   logic       nack, next_nack;
   logic [7:0] rd0, next_rd0;
   logic [7:0] rd1, next_rd1;
   logic       sda_meta;
   logic       sda_sync;
   logic       tick;
   logic       rx;
   logic [2:0] last_k;

   function automatic logic [7:0] tx_byte(input logic [2:0] idx);
      if (idx == 3'h0) begin
         tx_byte = {DEV_CODE, i_sel, i_rnw};
      end else if (idx == 3'h1) begin
         tx_byte = i_rnw ? 8'hff : i_cmd;
      end else if (idx == 3'h2) begin
         tx_byte = i_wdata0;
      end else begin
         tx_byte = i_wdata1;
      end
   endfunction

   assign link.scl     = scl;
   assign link.m_sda_o = 1'b0;
   assign link.m_sda_oe = oe;
   assign o_busy   = (state != dw_pkg::MS_IDLE);
   assign o_done   = done;
   assign o_nack   = nack;
   assign o_rdata0 = rd0;
   assign o_rdata1 = rd1;
   assign tick     = (qcnt == QTR_LAST);
   assign rx       = i_rnw && (k != 3'h0);
   assign last_k   = i_rnw ? {1'b0, i_len} : ({1'b0, i_len} + 3'h1);

   always_comb begin
      next_state = state;
      next_qcnt  = tick ? 8'h00 : qcnt + 8'h01;
      next_q     = q;
      next_bi    = bi;
      next_k     = k;
      next_sh    = sh;
      next_scl   = scl;
      next_oe    = oe;
      next_done  = 1'b0;
      next_nack  = nack;
      next_rd0   = rd0;
      next_rd1   = rd1;
      if (state == dw_pkg::MS_IDLE) begin
         next_scl = 1'b1;
         next_oe  = 1'b0;
         next_q   = 2'h0;
         if (i_go) begin
            next_state = dw_pkg::MS_START;
            next_qcnt  = 8'h00;
            next_nack  = 1'b0;
         end
      end else if (tick) begin
         next_q = q + 2'h1;
         unique case (state)
            dw_pkg::MS_IDLE: begin
               next_q = 2'h0;
            end
            dw_pkg::MS_START: begin
               if (q == 2'h1) begin
                  next_oe = 1'b1;
               end else if (q == 2'h3) begin
                  next_scl   = 1'b0;
                  next_state = dw_pkg::MS_BIT;
                  next_bi    = 4'h0;
                  next_k     = 3'h0;
                  next_sh    = tx_byte(3'h0);
               end
            end
            dw_pkg::MS_BIT: begin
               if (q == 2'h0) begin
                  if (bi != dw_pkg::ACK_CNT) begin
                     next_oe = !rx && !sh[7];
                  end else begin
                     next_oe = rx && (k != last_k);
                  end
               end else if (q == 2'h1) begin
                  next_scl = 1'b1;
               end else if (q == 2'h3) begin
                  next_scl = 1'b0;
                  if (bi != dw_pkg::ACK_CNT) begin
                     next_sh = {sh[6:0], sda_sync};
                     next_bi = bi + 4'h1;
                  end else begin
                     if (rx && (k == 3'h1)) next_rd0 = sh;
                     if (rx && (k == 3'h2)) next_rd1 = sh;
                     if (!rx && sda_sync) begin
                        next_nack  = 1'b1;
                        next_state = dw_pkg::MS_STOP;
                     end else if (k == last_k) begin
                        next_state = dw_pkg::MS_STOP;
                     end else begin
                        next_k  = k + 3'h1;
                        next_bi = 4'h0;
                        next_sh = tx_byte(k + 3'h1);
                     end
                  end
               end
            end
            dw_pkg::MS_STOP: begin
               if (q == 2'h0) begin
                  next_oe = 1'b1;
               end else if (q == 2'h1) begin
                  next_scl = 1'b1;
               end else if (q == 2'h3) begin
                  next_oe    = 1'b0;
                  next_state = dw_pkg::MS_IDLE;
                  next_done  = 1'b1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state    <= dw_pkg::MS_IDLE;
         qcnt     <= 8'h00;
         q        <= 2'h0;
         bi       <= 4'h0;
         k        <= 3'h0;
         sh       <= 8'h00;
         scl      <= 1'b1;
         oe       <= 1'b0;
         done     <= 1'b0;
         nack     <= 1'b0;
         rd0      <= 8'h00;
         rd1      <= 8'h00;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end else begin
         state    <= next_state;
         qcnt     <= next_qcnt;
         q        <= next_q;
         bi       <= next_bi;
         k        <= next_k;
         sh       <= next_sh;
         scl      <= next_scl;
         oe       <= next_oe;
         done     <= next_done;
         nack     <= next_nack;
         rd0      <= next_rd0;
         rd1      <= next_rd1;
         sda_meta <= link.sda;
         sda_sync <= sda_meta;
      end
   end

endmodule

/* File: testbench/dw_asserts.sv */
/*
 Concurrent checks on the two-wire link between the master end and the wiper end.
 Assumes its inputs come straight from the link interface and the master clock.
*/
`timescale 1ns/1ps
module dw_asserts (
   input  wire logic i_sys_clk,
   input  wire logic i_rst_n,
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic m_sda_oe,
   input  wire logic s_sda_oe
);
   logic [7:0] rise_cnt;
   logic [7:0] next_rise_cnt;
   logic       rd_dir;
   logic       next_rd_dir;
   logic       rd_end;
   logic       next_rd_end;
   logic       scl_q;
   logic       sda_q;

   // Clock rises since the last START; parked at ff before the first one
   always_comb begin
      next_rise_cnt = rise_cnt;
      next_rd_dir   = rd_dir;
      next_rd_end   = rd_end;
      if (scl && scl_q && sda_q && !sda) begin
         next_rise_cnt = 8'h00;
         next_rd_end   = 1'b0;
      end else if (scl && !scl_q && rise_cnt != 8'hff) begin
         next_rise_cnt = rise_cnt + 8'h01;
         // Nack on a read: the next clock rise belongs to STOP
         if (rd_dir && sda && (rise_cnt == 8'h08 || rise_cnt == 8'h11 || rise_cnt == 8'h1a)) begin
            next_rd_end = 1'b1;
         end
         if (rise_cnt == 8'h07) begin
            next_rd_dir = sda;
         end
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rise_cnt <= 8'hff;
         rd_dir   <= 1'b0;
         rd_end   <= 1'b0;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
      end else begin
         rise_cnt <= next_rise_cnt;
         rd_dir   <= next_rd_dir;
         rd_end   <= next_rd_end;
         scl_q    <= scl;
         sda_q    <= sda;
      end
   end

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_start;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence s_stop;
      scl && $past(scl) && $rose(sda);
   endsequence
   sequence s_ack_hold;
      (scl && s_sda_oe && !sda) [*8];
   endsequence

   property p_dev_edge;
      $changed(s_sda_oe) |-> $fell(scl);
   endproperty
   property p_start_idle;
      s_start |-> $past(sda, 2) && $past(scl, 2);
   endproperty
   property p_stop_idle;
      s_stop |=> (scl && sda) [*4];
   endproperty
   property p_ctrl_quiet;
      rise_cnt < 8'h08 |-> !s_sda_oe;
   endproperty
   property p_mst_ack_rel;
      $rose(scl) && (rise_cnt == 8'h08 || (!rd_dir && rise_cnt % 8'h09 == 8'h08)) |-> !m_sda_oe;
   endproperty
   property p_ack_held;
      $rose(scl) && rise_cnt == 8'h08 && s_sda_oe |-> s_ack_hold;
   endproperty
   property p_nack_rel;
      $rose(scl) && rd_dir && (rise_cnt == 8'h11 || rise_cnt == 8'h1a) && sda |-> !s_sda_oe throughout ##[1:64] s_stop;
   endproperty
   property p_rd_bits;
      $rose(scl) && rd_dir && !rd_end && rise_cnt > 8'h08 && rise_cnt < 8'h1a &&
      rise_cnt % 8'h09 != 8'h08 |-> !m_sda_oe;
   endproperty
   property p_nomatch;
      $rose(scl) && rise_cnt == 8'h08 && sda |-> !s_sda_oe throughout ##[1:400] (s_start or s_stop);
   endproperty

   a_dev_edge : assert property (p_dev_edge) else $error("device data moved outside falling clock");
   a_start_idle : assert property (p_start_idle) else $error("start issued on a busy bus");
   a_stop_idle : assert property (p_stop_idle) else $error("bus not idle after stop");
   a_ctrl_quiet : assert property (p_ctrl_quiet) else $error("device drove data during control byte");
   a_mst_ack_rel : assert property (p_mst_ack_rel) else $error("master drove the device ack slot");
   a_ack_held : assert property (p_ack_held) else $error("ack not held low through clock high");
   a_nack_rel : assert property (p_nack_rel) else $error("device kept data after master nack");
   a_rd_bits : assert property (p_rd_bits) else $error("master drove data during read byte");
   a_nomatch : assert property (p_nomatch) else $error("unselected device drove data");
endmodule

/* File: testbench/dual_wiper_two_wire_slave_bench.sv */
/*
 Self-checking bench: master end and wiper end joined by the link interface,
 compared with a wiper model. Assumes the package and both ends compile first.
*/
`timescale 1ns/1ps
module dual_wiper_two_wire_slave_bench;
   logic        sys_clk;
   logic        rst_n;
   logic        go;
   logic        rnw;
   logic [2:0]  sel;
   logic [2:0]  dev_sel;
   logic [7:0]  cmd;
   logic [7:0]  wd0;
   logic [7:0]  wd1;
   logic [1:0]  len;
   logic        done;
   logic        busy;
   logic        nack;
   logic [7:0]  rd0;
   logic [7:0]  rd1;
   logic [7:0]  wp0;
   logic [7:0]  wp1;
   logic [31:0] seed;
   logic [7:0]  cmds [4];
   int          error_cnt;
   int          check_count;
   int          m_w0;
   int          m_w1;
   int          rdq [$];

   dw_link_if link ();
   dw_mst_end dw_mst_end_i (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .link(link), .i_go(go), .i_rnw(rnw),
      .i_sel(sel), .i_cmd(cmd), .i_wdata0(wd0), .i_wdata1(wd1), .i_len(len), .o_busy(busy), .o_done(done),
      .o_nack(nack), .o_rdata0(rd0), .o_rdata1(rd1));
   dw_dev_end dw_dev_end_i (.i_rst_n(rst_n), .link(link), .i_device_select_pin_bit0(dev_sel[0]),
      .i_device_select_pin_bit1(dev_sel[1]), .i_device_select_pin_bit2(dev_sel[2]),
      .o_wiper_position_0(wp0), .o_wiper_position_1(wp1));
   dw_asserts dw_asserts_i (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .scl(link.scl), .sda(link.sda),
      .m_sda_oe(link.m_sda_oe), .s_sda_oe(link.s_sda_oe));

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_bit(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // One whole transfer, then the model is updated and compared
   task automatic xfer(input logic r, input logic [2:0] s, input logic [7:0] c, input logic [7:0] d0,
                       input logic [7:0] d1, input logic [1:0] n);
      int k;
      @(negedge sys_clk);
      rnw = r;
      sel = s;
      cmd = c;
      wd0 = d0;
      wd1 = d1;
      len = n;
      go = 1'b1;
      @(negedge sys_clk);
      go = 1'b0;
      cmp_bit("busy", 1'b1, busy);
      for (k = 0; k < 4000 && done !== 1'b1; k++) begin
         @(negedge sys_clk);
      end
      if (done !== 1'b1) begin
         error_cnt++;
         $display("mismatch done expected 1 seen %b", done);
         complete_run();
      end
      cmp_bit("busy", 1'b0, busy);
      if (s === dev_sel && !r && n != 2'd0) begin
         if (c == dw_pkg::CMD_WR0) begin
            m_w0 = d0;
            if (n == 2'd2) m_w1 = d1;
         end else if (c == dw_pkg::CMD_WR1) begin
            m_w1 = d0;
         end else if (c == dw_pkg::CMD_WRB) begin
            m_w0 = d0;
            m_w1 = d0;
         end
      end
      cmp_bit("nack", logic'(s !== dev_sel), nack);
      if (s === dev_sel && r) begin
         rdq = {m_w0, m_w1};
         cmp_byte("rdata0", rdq[0][7:0], rd0);
         if (n == 2'd2) cmp_byte("rdata1", rdq[1][7:0], rd1);
      end
      cmp_byte("wiper0", m_w0[7:0], wp0);
      cmp_byte("wiper1", m_w1[7:0], wp1);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   initial begin
      int i;
      int j;
      rst_n = 1'b0;
      go = 1'b0;
      rnw = 1'b0;
      sel = 3'h0;
      cmd = 8'h00;
      wd0 = 8'h00;
      wd1 = 8'h00;
      len = 2'h0;
      error_cnt = 0;
      check_count = 0;
      m_w0 = 0;
      m_w1 = 0;
      cmds = '{dw_pkg::CMD_WR0, dw_pkg::CMD_WR1, dw_pkg::CMD_WRB, 8'h55};
      seed = xs(32'h2a38);
      dev_sel = seed[2:0];
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      cmp_byte("wiper0", 8'h00, wp0);
      cmp_byte("wiper1", 8'h00, wp1);
      xfer(1'b1, dev_sel, 8'h00, 8'h00, 8'h00, 2'h2);
      $display("test reset_read done");
      for (i = 0; i < 12; i++) begin
         seed = xs(seed);
         xfer(1'b0, dev_sel, cmds[i % 4], seed[7:0], seed[15:8], 2'(1 + (i / 4) % 2));
         xfer(1'b1, dev_sel, 8'h00, 8'h00, 8'h00, 2'h2);
      end
      $display("test write_commands done");
      xfer(1'b0, dev_sel, dw_pkg::CMD_WRB, dw_pkg::WIPER_HIGH_END, 8'h00, 2'h1);
      xfer(1'b1, dev_sel, 8'h00, 8'h00, 8'h00, 2'h1);
      xfer(1'b0, dev_sel, dw_pkg::CMD_WR0, 8'h12, 8'h34, 2'h0);
      $display("test boundary done");
      for (j = 1; j < 8; j++) begin
         xfer(1'b0, dev_sel ^ 3'(j), dw_pkg::CMD_WRB, 8'h5a, 8'h00, 2'h1);
      end
      xfer(1'b1, dev_sel ^ 3'h4, 8'h00, 8'h00, 8'h00, 2'h2);
      $display("test select_mismatch done");
      rst_n = 1'b0;
      repeat (3) @(negedge sys_clk);
      rst_n = 1'b1;
      m_w0 = 0;
      m_w1 = 0;
      cmp_byte("wiper0", 8'h00, wp0);
      cmp_byte("wiper1", 8'h00, wp1);
      xfer(1'b1, dev_sel, 8'h00, 8'h00, 8'h00, 2'h2);
      $display("test second_reset done");
      complete_run();
   end
endmodule
